/* design/encgr_pkg.sv */
/*
  Constants, field layouts and carrier types for the encoder group
  register block. Assumes a byte-wide register port and one clock.
*/
package encgr_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_GROUPS = 4;
    localparam int CH_PER_GROUP = 3;
    localparam int NUM_CH = NUM_GROUPS * CH_PER_GROUP;
    localparam int NUM_LEVELS = 7;

    // ------------------------------------------------------------
    // Offsets: group base is addr[7:6], channel is addr[5:4]
    // ------------------------------------------------------------
    localparam logic [7:0] GRP_STRIDE = 8'h40;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [1:0] GRP_REGS_SLOT = 2'h3;
    localparam logic [5:0] OFF_MODE = 6'h33;
    localparam logic [5:0] OFF_GRESET = 6'h37;
    localparam logic [5:0] OFF_ICTRL = 6'h3b;
    localparam logic [5:0] OFF_IVEC = 6'h3f;
    localparam logic [3:0] OFF_CNT_MSB = 4'h0;
    localparam logic [3:0] OFF_CNT_LSB = 4'h3;
    localparam logic [3:0] OFF_MCTRL = 4'h5;
    localparam logic [3:0] OFF_MSTAT = 4'h7;
    localparam logic [3:0] OFF_LIVE = 4'h9;
    localparam logic [3:0] OFF_CMP = 4'hb;
    localparam logic [3:0] OFF_SNAP = 4'hd;
    localparam logic [3:0] OFF_MASK = 4'hf;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MC_CLR_EN_BIT = 0;
    localparam int MC_POL_BIT = 1;
    localparam int AUX_BIT = 0;
    localparam int MARK_BIT = 1;
    localparam logic [7:0] IVEC_RESET = 8'h0f;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] SEL_RESET = 2'h0;

    // ------------------------------------------------------------
    // Mode select codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_COUNTER = 3'h0;
    localparam logic [2:0] MODE_SGL_A = 3'h1;
    localparam logic [2:0] MODE_SGL_B = 3'h2;
    localparam logic [2:0] MODE_DBL_A = 3'h3;
    localparam logic [2:0] MODE_DBL_B = 3'h4;
    localparam logic [2:0] MODE_QUAD = 3'h5;
    localparam logic [2:0] MODE_PWIDTH = 3'h6;
    localparam logic [2:0] MODE_FREQ = 3'h7;

    // ------------------------------------------------------------
    // Timing: measurement clock derived from the system clock
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int MEAS_CLK_HZ = 10_000_000;
    localparam int MEAS_DIV_CYCLES = CLK_HZ / MEAS_CLK_HZ;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic flag;
        logic flag_auto_clear;
        logic vec_external;
        logic irq_request_enable;
        logic enable_auto_clear;
        logic [2:0] irq_level;
    } encgr_ictrl_t;
    localparam encgr_ictrl_t ICTRL_RESET = '0;

    typedef struct packed {
        logic req;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } encgr_acc_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } encgr_acc_ans_t;

    typedef struct packed {
        logic req;
        logic [2:0] level;
    } encgr_iack_t;

    typedef struct packed {
        logic ack;
        logic pass;
        logic [7:0] vector;
    } encgr_iack_ans_t;

    typedef struct packed {
        logic quad_a;
        logic quad_b;
        logic marker_line;
        logic aux_line;
    } encgr_pins_t;

endpackage

/* design/encgr_regs.sv */
/*
  Register block of a twelve channel quadrature encoder board: counters,
  marker handling, change-of-state detection and the group interrupter.
  Assumes the bus side arrives already decoded to a byte port on clk;
  encoder pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps

module encgr_regs #(
    parameter int MEAS_DIV = encgr_pkg::MEAS_DIV_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register access port
    input wire encgr_pkg::encgr_acc_t acc,
    output encgr_pkg::encgr_acc_ans_t acc_ans_r,
    // Interrupt acknowledge
    input wire encgr_pkg::encgr_iack_t iack,
    output encgr_pkg::encgr_iack_ans_t iack_ans_r,
    // Interrupt request lines, bit 0 is level 1
    output logic [encgr_pkg::NUM_LEVELS-1:0] irq_r,
    // Encoder pins
    input wire encgr_pkg::encgr_pins_t [encgr_pkg::NUM_CH-1:0] pins
);
    import encgr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte k of a counter, k = 0 is bits 31..24
    function automatic logic [7:0] cnt_byte(input logic [31:0] v,
                                            input logic [1:0] k);
        logic [7:0] b;
        b = 8'h00;
        unique case (k)
            2'd0: b = v[31:24];
            2'd1: b = v[23:16];
            2'd2: b = v[15:8];
            2'd3: b = v[7:0];
        endcase
        return b;
    endfunction

    // Count step {up, down} for one channel
    function automatic logic [1:0] step(input logic [2:0] m,
        input logic a, input logic b, input logic pa, input logic pb,
        input logic tick);
        logic ae;
        logic be;
        logic x;
        logic [1:0] s;
        ae = a ^ pa;
        be = b ^ pb;
        x = a ^ b;
        s = 2'b00;
        case (m)
            MODE_SGL_A: s = {ae & a & ~b, ae & ~a & ~b};
            MODE_SGL_B: s = {be & a & b, be & a & ~b};
            MODE_DBL_A: s = {ae & x, ae & ~x};
            MODE_DBL_B: s = {be & ~x, be & x};
            MODE_QUAD: s = {(ae & x) | (be & ~x),
                            (ae & ~x) | (be & x)};
            MODE_PWIDTH: s = {tick & a & b, tick & a & ~b};
            MODE_FREQ: s = {b & a & ~pa, 1'b0};
            default: s = 2'b00;
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    encgr_pins_t [NUM_CH-1:0] meta_r;
    encgr_pins_t [NUM_CH-1:0] sync_r;
    encgr_pins_t [NUM_CH-1:0] prev_r;
    logic [NUM_CH-1:0][31:0] cnt_r;
    logic [NUM_CH-1:0][31:0] latch_r;
    logic [NUM_CH-1:0] seen_r;
    logic [NUM_CH-1:0][1:0] sel_r;
    logic [NUM_CH-1:0][1:0] mctrl_r;
    logic [NUM_CH-1:0] mflag_r;
    logic [NUM_CH-1:0][1:0] cmp_r;
    logic [NUM_CH-1:0][1:0] snap_r;
    logic [NUM_CH-1:0][1:0] mask_r;
    logic [NUM_GROUPS-1:0][2:0] mode_r;
    encgr_ictrl_t [NUM_GROUPS-1:0] ictrl_r;
    logic [NUM_GROUPS-1:0][7:0] ivec_r;
    logic [NUM_GROUPS-1:0] pend_r;
    logic [NUM_GROUPS-1:0] armed_r;
    logic [7:0] div_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic rd;
    logic wr;
    logic is_chan;
    logic [1:0] grp;
    logic [5:0] goff;
    logic [3:0] coff;
    logic [3:0] ch_idx;
    logic is_cnt;
    logic trig;

    // Group from addr[7:6], channel from addr[5:4]
    assign rd = acc.req & ~acc.write;
    assign wr = acc.req & acc.write;
    assign grp = acc.addr[7:6];
    assign goff = acc.addr[5:0];
    assign coff = acc.addr[3:0];
    assign is_chan = acc.addr[5:4] != GRP_REGS_SLOT;
    assign ch_idx = 4'({2'b00, grp} * 4'd3) + {2'b00, acc.addr[5:4]};
    assign is_cnt = is_chan && coff <= OFF_CNT_LSB && coff >= OFF_CNT_MSB;
    // Latch fires on the first byte ever read, then only on that byte
    assign trig = rd & is_cnt
        & (~seen_r[ch_idx] | sel_r[ch_idx] == coff[1:0]);

    // ------------------------------------------------------------
    // Pin synchronisers, two stages then an edge history stage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Measurement tick at the 10 MHz rate
    always_ff @(posedge clk) begin
        if (reset || div_r == 8'(MEAS_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 8'd1;
        end
    end

    // ------------------------------------------------------------
    // Per-channel events
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] up;
    logic [NUM_CH-1:0] dn;
    logic [NUM_CH-1:0] gate_end;
    logic [NUM_CH-1:0] mark_evt;
    logic [NUM_GROUPS-1:0] grp_reset;
    logic [NUM_GROUPS-1:0] mism;

    always_comb begin
        logic [1:0] s;
        logic [2:0] m;
        logic act;
        logic pact;
        s = 2'b00;
        m = MODE_RESET;
        act = 1'b0;
        pact = 1'b0;
        mism = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            grp_reset[g] = wr & ~is_chan & grp == 2'(g)
                & goff == OFF_GRESET;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            m = mode_r[c / CH_PER_GROUP];
            s = step(m, sync_r[c].quad_a, sync_r[c].quad_b,
                     prev_r[c].quad_a, prev_r[c].quad_b, div_r == 8'd0);
            up[c] = s[1];
            dn[c] = s[0];
            // Gate fall ends a measurement window
            gate_end[c] = (m == MODE_PWIDTH && prev_r[c].quad_a
                           && !sync_r[c].quad_a)
                        | (m == MODE_FREQ && prev_r[c].quad_b
                           && !sync_r[c].quad_b);
            // Pulse counts when the line returns to its idle level
            act = ~(sync_r[c].marker_line ^ mctrl_r[c][MC_POL_BIT]);
            pact = ~(prev_r[c].marker_line ^ mctrl_r[c][MC_POL_BIT]);
            mark_evt[c] = pact & ~act;
            if (|(({sync_r[c].marker_line, sync_r[c].aux_line}
                   ^ cmp_r[c]) & mask_r[c])) begin
                mism[c / CH_PER_GROUP] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    // Group reset and marker clear outrank counting
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                cnt_r[c] <= '0;
            end else if (grp_reset[c / CH_PER_GROUP]) begin
                cnt_r[c] <= '0;
            end else if (mark_evt[c] && mctrl_r[c][MC_CLR_EN_BIT]) begin
                cnt_r[c] <= '0;
            end else if (gate_end[c]) begin
                cnt_r[c] <= '0;
            end else if (wr && is_cnt && ch_idx == 4'(c)) begin
                unique case (coff[1:0])
                    2'd0: cnt_r[c][31:24] <= acc.wdata;
                    2'd1: cnt_r[c][23:16] <= acc.wdata;
                    2'd2: cnt_r[c][15:8] <= acc.wdata;
                    2'd3: cnt_r[c][7:0] <= acc.wdata;
                endcase
            end else if (up[c]) begin
                cnt_r[c] <= cnt_r[c] + 32'd1;
            end else if (dn[c]) begin
                cnt_r[c] <= cnt_r[c] - 32'd1;
            end
        end
    end

    // Output latch and the byte that triggers it
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                latch_r[c] <= '0;
                seen_r[c] <= 1'b0;
                sel_r[c] <= SEL_RESET;
            end else if (trig && ch_idx == 4'(c)) begin
                latch_r[c] <= cnt_r[c];
                seen_r[c] <= 1'b1;
                sel_r[c] <= coff[1:0];
            end else if (gate_end[c]) begin
                latch_r[c] <= cnt_r[c];
            end
        end
    end

    // ------------------------------------------------------------
    // Marker control and event flag
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                mctrl_r[c] <= '0;
            end else if (wr && is_chan && ch_idx == 4'(c)
                         && coff == OFF_MCTRL) begin
                mctrl_r[c] <= acc.wdata[1:0];
            end
        end
    end

    // A pulse in the clearing read's cycle still sets the flag
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                mflag_r[c] <= 1'b0;
            end else if (mark_evt[c] && mctrl_r[c][MC_CLR_EN_BIT]) begin
                mflag_r[c] <= 1'b1;
            end else if (rd && is_chan && ch_idx == 4'(c)
                         && coff == OFF_MSTAT) begin
                mflag_r[c] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Change-of-state: compare, mask, snapshot
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                cmp_r[c] <= '0;
                mask_r[c] <= '0;
            end else if (wr && is_chan && ch_idx == 4'(c)) begin
                if (coff == OFF_CMP) begin
                    cmp_r[c] <= acc.wdata[1:0];
                end
                if (coff == OFF_MASK) begin
                    mask_r[c] <= acc.wdata[1:0];
                end
            end
        end
    end

    // Snapshot taken whenever an armed group sees a mismatch, even when a compare write keeps it armed
    always_ff @(posedge clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (reset) begin
                snap_r[c] <= '0;
            end else if (armed_r[c / CH_PER_GROUP]
                         && mism[c / CH_PER_GROUP]) begin
                snap_r[c] <= {sync_r[c].marker_line,
                              sync_r[c].aux_line};
            end
        end
    end

    // Compare write clears the request; a still-present mismatch
    // is seen again on the next edge, so no change is lost
    always_ff @(posedge clk) begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (reset) begin
                pend_r[g] <= 1'b0;
                armed_r[g] <= 1'b1;
            end else if (wr && is_chan && grp == 2'(g)
                         && coff == OFF_CMP) begin
                pend_r[g] <= 1'b0;
                armed_r[g] <= 1'b1;
            end else if (armed_r[g] && mism[g]) begin
                pend_r[g] <= 1'b1;
                armed_r[g] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Group registers and interrupter
    // ------------------------------------------------------------
    logic [NUM_GROUPS-1:0] req;
    logic iack_hit;
    logic [1:0] iack_grp;

    always_comb begin
        iack_hit = 1'b0;
        iack_grp = 2'd0;
        for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
            req[g] = pend_r[g] & ictrl_r[g].irq_request_enable
                & ictrl_r[g].irq_level != 3'd0;
            // Lowest group wins when several share a level
            if (iack.req && req[g] && ictrl_r[g].irq_level == iack.level
                && !ictrl_r[g].vec_external) begin
                iack_hit = 1'b1;
                iack_grp = 2'(g);
            end
        end
    end

    // Mode selects the count step of all three channels in the group
    always_ff @(posedge clk) begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (reset) begin
                mode_r[g] <= MODE_RESET;
                ivec_r[g] <= IVEC_RESET;
            end else if (wr && !is_chan && grp == 2'(g)) begin
                if (goff == OFF_MODE) begin
                    mode_r[g] <= acc.wdata[2:0];
                end
                if (goff == OFF_IVEC) begin
                    ivec_r[g] <= acc.wdata;
                end
            end
        end
    end

    // Software writes take precedence over acknowledge clears
    always_ff @(posedge clk) begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (reset) begin
                ictrl_r[g] <= ICTRL_RESET;
            end else if (wr && !is_chan && grp == 2'(g)
                         && goff == OFF_ICTRL) begin
                ictrl_r[g] <= acc.wdata;
            end else if (iack_hit && iack_grp == 2'(g)) begin
                if (ictrl_r[g].enable_auto_clear) begin
                    ictrl_r[g].irq_request_enable <= 1'b0;
                end
                if (ictrl_r[g].flag_auto_clear) begin
                    ictrl_r[g].flag <= 1'b0;
                end
            end
        end
    end

    // Level lines
    always_ff @(posedge clk) begin
        for (int l = 0; l < NUM_LEVELS; l++) begin
            if (reset) begin
                irq_r[l] <= 1'b0;
            end else begin
                irq_r[l] <= 1'b0;
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (req[g] && ictrl_r[g].irq_level == 3'(l + 1)) begin
                        irq_r[l] <= 1'b1;
                    end
                end
            end
        end
    end

    // Acknowledge answer: vector, or pass down the chain
    always_ff @(posedge clk) begin
        if (reset) begin
            iack_ans_r <= '0;
        end else begin
            iack_ans_r.ack <= iack_hit;
            iack_ans_r.pass <= iack.req & ~iack_hit;
            iack_ans_r.vector <= iack_hit ? ivec_r[iack_grp] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = 8'h00;
        if (is_chan) begin
            if (is_cnt) begin
                // Triggering read returns the value it latches
                rdata_nxt = cnt_byte(trig ? cnt_r[ch_idx]
                                     : latch_r[ch_idx], coff[1:0]);
            end else begin
                case (coff)
                    OFF_MCTRL: rdata_nxt = {6'h00, mctrl_r[ch_idx]};
                    OFF_MSTAT: rdata_nxt = {7'h00, mflag_r[ch_idx]};
                    OFF_LIVE: rdata_nxt = {6'h00,
                        sync_r[ch_idx].marker_line,
                        sync_r[ch_idx].aux_line};
                    OFF_CMP: rdata_nxt = {6'h00, cmp_r[ch_idx]};
                    OFF_SNAP: rdata_nxt = {6'h00, snap_r[ch_idx]};
                    OFF_MASK: rdata_nxt = {6'h00, mask_r[ch_idx]};
                    default: rdata_nxt = 8'h00;
                endcase
            end
        end else begin
            case (goff)
                OFF_MODE: rdata_nxt = {5'h00, mode_r[grp]};
                OFF_ICTRL: rdata_nxt = ictrl_r[grp];
                OFF_IVEC: rdata_nxt = ivec_r[grp];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Every access in the window is answered one edge later
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_ans_r <= '0;
        end else begin
            acc_ans_r.ack <= acc.req;
            acc_ans_r.rdata <= rd ? rdata_nxt : 8'h00;
        end
    end

endmodule

/* tb/encgr_host.sv */
/* Bus master model: byte accesses and interrupt acknowledge.
   Assumes the block answers one edge after each request. */
`timescale 1ns/1ps
module encgr_host (
    // Clock
    input wire logic clk,
    // Requests and answers
    output encgr_pkg::encgr_acc_t acc,
    output encgr_pkg::encgr_iack_t iack,
    input wire encgr_pkg::encgr_acc_ans_t acc_ans_r,
    input wire encgr_pkg::encgr_iack_ans_t iack_ans_r
);
    import encgr_pkg::*;
    // Idle bus from time zero
    initial begin
        acc = '0;
        iack = '0;
    end
    // One access; a missing answer yields unknown data
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        acc <= '{1'b1, w, a, (a[5:0] == OFF_ICTRL) ? d & 8'hdf : d};
        @(posedge clk);
        acc <= '0;
        #1;
        q = acc_ans_r.ack ? acc_ans_r.rdata : 8'hxx;
    endtask
    // Acknowledge cycle at one level
    task automatic intack(input logic [2:0] l, output logic [7:0] v);
        @(posedge clk);
        iack <= '{1'b1, l};
        @(posedge clk);
        iack <= '0;
        #1;
        v = iack_ans_r.ack ? iack_ans_r.vector : 8'hxx;
    endtask
endmodule

/* tb/encgr_regs_tb_top.sv */
/* Register level tests of encgr_regs.
   Assumes encgr_host drives the bus and the bound checker. */
`timescale 1ns/1ps
module encgr_regs_tb_top;
    import encgr_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    encgr_acc_t acc;
    encgr_acc_ans_t acc_ans_r;
    encgr_iack_t iack;
    encgr_iack_ans_t iack_ans_r;
    logic [NUM_LEVELS-1:0] irq_r;
    encgr_pins_t [NUM_CH-1:0] pins = '0;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] q;
    always #2.5 clk = ~clk;
    // Small divider keeps measurement modes short
    encgr_regs #(.MEAS_DIV(2)) i_dut (.clk(clk), .reset(reset), .acc(acc),
        .acc_ans_r(acc_ans_r), .iack(iack), .iack_ans_r(iack_ans_r),
        .irq_r(irq_r), .pins(pins));
    encgr_host i_host (.clk(clk), .acc(acc), .iack(iack),
        .acc_ans_r(acc_ans_r), .iack_ans_r(iack_ans_r));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    // Request lines settle within three edges
    task automatic irqc(input logic [7:0] e);
        repeat (3) @(posedge clk);
        #1;
        chk({1'b0, irq_r}, e);
    endtask
    // Channel 0 pins {quad_a, quad_b, marker, aux}; four edges cover sync
    task automatic setp(input logic [3:0] v);
        @(posedge clk);
        pins[0] <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic results;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Guards against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rc(8'h3f, 8'h0f);
        rc(8'h45, 8'h00);
        rc(8'h8f, 8'h00);
        rc(8'h31, 8'h00);
        setp(4'h3);
        rc(8'h09, 8'h03);
        rc(8'h49, 8'h00);
        rc(8'h19, 8'h00);
        wr(8'h3b, 8'hda);
        wr(8'h0b, 8'h02);
        wr(8'h0f, 8'h02);
        irqc(8'h00);
        wr(8'h0f, 8'h01);
        irqc(8'h02);
        rc(8'h0d, 8'h03);
        i_host.intack(3'h2, q);
        chk(q, 8'h0f);
        chk({6'h00, iack_ans_r.ack, iack_ans_r.pass}, 8'h02);
        rc(8'h3b, 8'h4a);
        wr(8'h3b, 8'h80);
        rc(8'h3b, 8'h80);
        irqc(8'h00);
        wr(8'h3b, 8'h1a);
        wr(8'h0b, 8'h03);
        irqc(8'h00);
        setp(4'h2);
        irqc(8'h02);
        rc(8'h0d, 8'h02);
        for (int i = 0; i < 4; i++)
            wr(i[7:0], 8'h12 + 8'h22 * i[7:0]);
        for (int i = 0; i < 4; i++)
            rc(i[7:0], 8'h12 + 8'h22 * i[7:0]);
        wr(8'h03, 8'h99);
        rc(8'h03, 8'h78);
        wr(8'h37, 8'h00);
        rc(8'h00, 8'h00);
        wr(8'h05, 8'h01);
        wr(8'h03, 8'h55);
        setp(4'h0);
        setp(4'h2);
        rc(8'h07, 8'h01);
        rc(8'h07, 8'h00);
        rc(8'h00, 8'h00);
        rc(8'h03, 8'h00);
        // Quadruple mode: four forward edges, then two backward
        wr(8'h33, 8'h05);
        rc(8'h33, 8'h05);
        setp(4'ha);
        setp(4'he);
        setp(4'h6);
        setp(4'h2);
        rc(8'h00, 8'h00);
        rc(8'h03, 8'h04);
        setp(4'h6);
        setp(4'he);
        rc(8'h00, 8'h00);
        rc(8'h03, 8'h02);
        // Single pulse mode: one count per full forward cycle
        wr(8'h33, 8'h01);
        wr(8'h37, 8'h00);
        setp(4'h6);
        setp(4'h2);
        setp(4'ha);
        rc(8'h00, 8'h00);
        rc(8'h03, 8'h01);
        // Frequency mode: two quad_a rises inside the quad_b gate
        wr(8'h33, 8'h07);
        wr(8'h37, 8'h00);
        setp(4'h6);
        setp(4'he);
        setp(4'h6);
        setp(4'he);
        setp(4'ha);
        rc(8'h03, 8'h02);
        rc(8'h00, 8'h00);
        // No group at level 3, so the acknowledge is passed on
        i_host.intack(3'h3, q);
        chk({6'h00, iack_ans_r.ack, iack_ans_r.pass}, 8'h01);
        results();
    end
endmodule

/* tb/encgr_sva.sv */
/* Port checker for encgr_regs.
   Assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
module encgr_sva #(
    parameter int MEAS_DIV = 2
) (
    // Watched ports
    input wire logic clk,
    input wire logic reset,
    input wire encgr_pkg::encgr_acc_t acc,
    input wire encgr_pkg::encgr_acc_ans_t acc_ans_r,
    input wire encgr_pkg::encgr_iack_t iack,
    input wire encgr_pkg::encgr_iack_ans_t iack_ans_r,
    input wire logic [encgr_pkg::NUM_LEVELS-1:0] irq_r,
    input wire encgr_pkg::encgr_pins_t [encgr_pkg::NUM_CH-1:0] pins
);
    import encgr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_ACK: assert property (acc.req |=> acc_ans_r.ack)
        else $error("access not answered");
    AST_IDLE: assert property (!acc.req |=> !acc_ans_r.ack)
        else $error("answer without access");
    AST_WR: assert property (acc.req && acc.write |=>
        acc_ans_r.rdata == 8'h00) else $error("write returned data");
    AST_GRST: assert property (acc.req && !acc.write &&
        acc.addr[5:0] == OFF_GRESET |=> acc_ans_r.rdata == 8'h00)
        else $error("reset trigger read not zero");
    AST_IACK: assert property (iack.req |=>
        iack_ans_r.ack != iack_ans_r.pass) else $error("bad iack answer");
    AST_IIDLE: assert property (!iack.req |=>
        !iack_ans_r.ack && !iack_ans_r.pass) else $error("stray iack answer");
    AST_VEC: assert property (!iack_ans_r.ack |->
        iack_ans_r.vector == 8'h00) else $error("vector without ack");
    AST_LVL: assert property (iack.req && iack.level != 3'h0 &&
        irq_r[iack.level - 3'h1] |=> iack_ans_r.ack)
        else $error("raised level not acknowledged");
endmodule

bind encgr_regs encgr_sva #(.MEAS_DIV(MEAS_DIV)) i_sva (.clk(clk),
    .reset(reset), .acc(acc), .acc_ans_r(acc_ans_r), .iack(iack),
    .iack_ans_r(iack_ans_r), .irq_r(irq_r), .pins(pins));
